// >>> hw/ctu_charge_timer.sv
// module: control logic of the charge timer unit
// What this block does
// - setting first edge flag starts charging; clearing it stops charging
// - time mode charges only between first and second edge events
// - delay-gen enable selects pulse-delay mode with pulse output
// - in delay mode pulse follows comparator trip after first flag set
// - delay trip comes from comparator 2 against internal reference
// - any sleep mode forces the current source off
// - stop-in-idle bit set disables current source in idle
// - reset clears the edge flags and the delay sequencer; source off
// - reset during a measurement abandons it, keeping nothing
// - peripheral disable freezes flags and sequencer and turns the source off
// - with ordering on, second edge ignored until first edge seen
// - edge gate clear blocks edges from changing flags
// - two-bit source select and polarity bit per edge
// - range field sets current magnitude; zero disables source
`timescale 1ns/100ps
module ctu_charge_timer
  import ctu_pkg::*;
(
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // power state
  input  wire logic          sleep_mode,
  input  wire logic          idle_mode,
  input  wire logic          peripheral_disable,
  // control bits, held by software
  input  wire logic          unit_enable,
  input  wire logic          stop_in_idle,
  input  wire logic          delay_gen_enable,
  input  wire logic          edge_gate,
  input  wire logic          edge_order_enable,
  input  wire logic          discharge_ground,
  input  wire logic [1:0]    current_range,
  input  ctu_edge_cfg_t      first_edge_cfg,
  input  ctu_edge_cfg_t      second_edge_cfg,
  // software flag writes, one-cycle strobes
  input  wire logic          first_flag_wr,
  input  wire logic          first_flag_wdata,
  input  wire logic          second_flag_wr,
  input  wire logic          second_flag_wdata,
  // edge event sources from pins and capture units
  input  wire logic          first_edge_pin,
  input  wire logic          second_edge_pin,
  input  wire logic          enhanced_capture_one,
  input  wire logic          capture_unit_two,
  // comparator 2 output: capacitor above reference
  input  wire logic          comparator_trip,
  // status
  output logic               first_edge_flag,
  output logic               second_edge_flag,
  // analog control
  output logic               source_on,
  output logic [1:0]         source_range,
  output logic               source_grounded,
  output logic               pulse_out_pin
);

  // internal state
  logic           gclk_en;
  logic [3:0]     sync1_reg;
  logic [3:0]     sync2_reg;
  logic           trip1_reg;
  logic           trip2_reg;
  ctu_edge_src_t  src_lvl;
  logic           hit1;
  logic           hit2;
  logic           f1_reg;
  logic           f1_next;
  logic           f2_reg;
  logic           f2_next;
  logic           on_reg;
  logic           on_next;
  logic           pls_reg;
  logic           pls_next;
  logic           trip_prev_reg;
  logic           trip_prev_next;
  ctu_dly_state_t st_reg;
  ctu_dly_state_t st_next;
  logic           src_ok;

  // disabled module: flags and sequencer hold, source_on is cleared
  assign gclk_en = ~peripheral_disable;

  // two-stage synchronisers for all asynchronous inputs
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      trip1_reg <= 1'b0;
      trip2_reg <= 1'b0;
    end else begin
      sync1_reg <= {first_edge_pin, second_edge_pin,
                    enhanced_capture_one, capture_unit_two};
      sync2_reg <= sync1_reg;
      trip1_reg <= comparator_trip;
      trip2_reg <= trip1_reg;
    end
  end

  assign src_lvl = ctu_edge_src_t'(sync2_reg);

  // edge channel one
  ctu_edge_detect u_edge1 (
    .clk (clk),
    .rst (rst),
    .cfg (first_edge_cfg),
    .src (src_lvl),
    .hit (hit1)
  );

  // edge channel two
  ctu_edge_detect u_edge2 (
    .clk (clk),
    .rst (rst),
    .cfg (second_edge_cfg),
    .src (src_lvl),
    .hit (hit2)
  );

  // edge flags: hardware set wins over a software clear
  always_comb begin
    f1_next = f1_reg;
    f2_next = f2_reg;
    if (gclk_en) begin
      if (first_flag_wr) begin
        f1_next = first_flag_wdata;
      end
      if (second_flag_wr) begin
        f2_next = second_flag_wdata;
      end
      if (unit_enable && edge_gate && hit1) begin
        f1_next = 1'b1;
      end
      // ordering: second edge counts only once first has occurred
      if (unit_enable && edge_gate && hit2 &&
          (!edge_order_enable || f1_reg)) begin
        f2_next = 1'b1;
      end
    end
  end

  // current source gating; charging resumes once a stop condition clears
  assign src_ok = unit_enable && (current_range != CTU_RNG_OFF)
                  && !discharge_ground && !sleep_mode
                  && !(idle_mode && stop_in_idle);

  always_comb begin
    on_next = src_ok && f1_next && !f2_next;
  end

  // pulse-delay sequencer
  always_comb begin
    st_next        = st_reg;
    pls_next       = pls_reg;
    trip_prev_next = trip2_reg;
    if (!delay_gen_enable || !unit_enable) begin
      st_next  = CTU_DLY_IDLE;
      pls_next = 1'b0;
    end else begin
      unique case (st_reg)
        CTU_DLY_IDLE: begin
          if (f1_reg && !trip2_reg) begin
            st_next = CTU_DLY_CHG;
          end
        end
        CTU_DLY_CHG: begin
          if (!f1_reg) begin
            st_next = CTU_DLY_IDLE;
          end else if (trip2_reg && !trip_prev_reg) begin
            st_next  = CTU_DLY_PULSE;
            pls_next = 1'b1;
          end
        end
        CTU_DLY_PULSE: begin
          // pulse ends when software clears the first flag
          if (!f1_reg) begin
            st_next  = CTU_DLY_IDLE;
            pls_next = 1'b0;
          end
        end
        default: begin
          st_next  = CTU_DLY_IDLE;
          pls_next = 1'b0;
        end
      endcase
    end
  end

  // state registers; reset discards any measurement in progress
  always_ff @(posedge clk) begin
    if (rst) begin
      f1_reg        <= CTU_FLAG_RESET;
      f2_reg        <= CTU_FLAG_RESET;
      on_reg        <= 1'b0;
      pls_reg       <= 1'b0;
      trip_prev_reg <= 1'b0;
      st_reg        <= CTU_DLY_IDLE;
    end else if (gclk_en) begin
      f1_reg        <= f1_next;
      f2_reg        <= f2_next;
      on_reg        <= on_next;
      pls_reg       <= pls_next;
      trip_prev_reg <= trip_prev_next;
      st_reg        <= st_next;
    end else begin
      on_reg        <= 1'b0;
    end
  end

  // outputs
  assign first_edge_flag  = f1_reg;
  assign second_edge_flag = f2_reg;
  assign source_on        = on_reg;
  assign source_range     = on_reg ? current_range : CTU_RNG_OFF;
  assign source_grounded  = unit_enable & discharge_ground;
  assign pulse_out_pin    = pls_reg;

  // checks
  sleep_src_off_a: assert property (@(posedge clk) disable iff (rst)
    sleep_mode |=> !source_on)
    else $error("source on after sleep");
  idle_src_off_a: assert property (@(posedge clk) disable iff (rst)
    (idle_mode && stop_in_idle) |=> !source_on)
    else $error("source on in idle stop");
  range_off_a: assert property (@(posedge clk) disable iff (rst)
    (current_range == CTU_RNG_OFF) |=> !source_on)
    else $error("source on with zero range");
  second_stops_a: assert property (@(posedge clk) disable iff (rst)
    second_edge_flag |-> !source_on)
    else $error("charging after second edge");
  gate_blocks_a: assert property (@(posedge clk) disable iff (rst)
    (!edge_gate && !first_flag_wr && !first_edge_flag
     && !peripheral_disable) |=> !first_edge_flag)
    else $error("edge passed closed gate");
  order_a: assert property (@(posedge clk) disable iff (rst)
    (edge_order_enable && !first_edge_flag && !second_edge_flag
     && !second_flag_wr) |=> !second_edge_flag)
    else $error("second edge before first");
  flag_sticky_a: assert property (@(posedge clk) disable iff (rst)
    (first_edge_flag && !first_flag_wr) |=> first_edge_flag)
    else $error("first flag dropped");
  pmd_hold_a: assert property (@(posedge clk) disable iff (rst)
    peripheral_disable |=> $stable(pulse_out_pin))
    else $error("state moved while disabled");
  pulse_mode_a: assert property (@(posedge clk) disable iff (rst)
    !delay_gen_enable |=> !pulse_out_pin)
    else $error("pulse outside delay mode");
  reset_clear_a: assert property (@(posedge clk)
    rst |=> !first_edge_flag && !source_on)
    else $error("state survived reset");

endmodule : ctu_charge_timer

// >>> hw/ctu_edge_detect.sv
// module: edge selector and detector for one edge channel
`timescale 1ns/100ps
module ctu_edge_detect
  import ctu_pkg::*;
(
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // configuration
  input  ctu_edge_cfg_t      cfg,
  // synchronised event levels
  input  ctu_edge_src_t      src,
  // one-cycle event on the selected polarity
  output logic               hit
);

  logic          sel_lvl;
  logic          sel_prev;
  ctu_edge_src_t prev_reg;
  ctu_edge_src_t prev_next;

  // level of the source named by a select code
  function automatic logic pick(input ctu_edge_src_t s,
                                input logic [1:0]    code);
    logic r;
    unique case (code)
      CTU_SRC_PIN1: r = s.pin1;
      CTU_SRC_PIN2: r = s.pin2;
      CTU_SRC_ECAP: r = s.ecap;
      CTU_SRC_CAP2: r = s.cap2;
    endcase
    return r;
  endfunction : pick

  // every source keeps its own history, so a change of the select
  // code cannot fake an edge out of two different sources
  always_comb begin
    sel_lvl   = pick(src, cfg.source);
    sel_prev  = pick(prev_reg, cfg.source);
    prev_next = src;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prev_reg <= ctu_edge_src_t'(4'h0);
    end else begin
      prev_reg <= prev_next;
    end
  end

  // polarity 1 means rising edge response
  assign hit = cfg.polarity ? (sel_lvl & ~sel_prev)
                            : (~sel_lvl & sel_prev);

endmodule : ctu_edge_detect

// >>> hw/ctu_pkg.sv
// package: shared constants and carrier types of the charge timer unit
package ctu_pkg;

  // edge source select codes
  localparam logic [1:0] CTU_SRC_PIN1   = 2'h3;
  localparam logic [1:0] CTU_SRC_PIN2   = 2'h2;
  localparam logic [1:0] CTU_SRC_ECAP   = 2'h1;
  localparam logic [1:0] CTU_SRC_CAP2   = 2'h0;

  // current range codes
  localparam logic [1:0] CTU_RNG_X100   = 2'h3;
  localparam logic [1:0] CTU_RNG_X10    = 2'h2;
  localparam logic [1:0] CTU_RNG_X1     = 2'h1;
  localparam logic [1:0] CTU_RNG_OFF    = 2'h0;

  // high control register field positions
  localparam int CTU_HI_ENABLE_BIT      = 7;
  localparam int CTU_HI_STOP_IDLE_BIT   = 5;
  localparam int CTU_HI_DELAY_GEN_BIT   = 4;
  localparam int CTU_HI_EDGE_GATE_BIT   = 3;
  localparam int CTU_HI_ORDER_BIT       = 2;
  localparam int CTU_HI_DISCHARGE_BIT   = 1;

  // value of every control bit after reset
  localparam logic [7:0] CTU_CTRL_RESET = 8'h00;
  localparam logic       CTU_FLAG_RESET = 1'b0;

  // edge configuration for one edge channel
  typedef struct packed {
    logic [1:0] source;
    logic       polarity;
  } ctu_edge_cfg_t;

  // raw edge event inputs, already synchronised
  typedef struct packed {
    logic pin1;
    logic pin2;
    logic ecap;
    logic cap2;
  } ctu_edge_src_t;

  // pulse-delay state machine
  typedef enum logic [1:0] {
    CTU_DLY_IDLE  = 2'b00,
    CTU_DLY_CHG   = 2'b01,
    CTU_DLY_PULSE = 2'b10
  } ctu_dly_state_t;

endpackage : ctu_pkg

// >>> sim/ctu_sensor_model.sv
// partner model: sensing capacitor charged by the unit, seen by comparator 2
`timescale 1ns/100ps
module ctu_sensor_model #(
  parameter int TRIP_LEVEL  = 20,
  parameter int CONV_CYCLES = 6
) (
  // clock
  input  wire logic clk,
  // analog control from the unit
  input  wire logic source_on,
  input  wire logic source_grounded,
  // converter start strobe
  input  wire logic adc_go,
  // comparator 2 output
  output logic      comparator_trip,
  // converter done flag and result
  output logic      adc_done_flag,
  output int        adc_result
);
  int charge = 0;
  int conv_cnt = 0;

  initial begin
    adc_done_flag = 1'b0;
    adc_result    = 0;
  end

  // converter: a start clears done, result is the held charge
  always @(posedge clk) begin
    if (adc_go) begin
      adc_done_flag <= 1'b0;
      conv_cnt      <= CONV_CYCLES;
    end else if (conv_cnt == 1) begin
      adc_result    <= charge;
      adc_done_flag <= 1'b1;
      conv_cnt      <= 0;
    end else if (conv_cnt > 1) begin
      conv_cnt      <= conv_cnt - 1;
    end
  end

  // charge holds while the source is off and not grounded, so stale charge can trip early
  always @(posedge clk) begin
    if (source_grounded)
      charge <= 0;
    else if (source_on)
      charge <= charge + 1;
  end

  // capacitor voltage against the internal reference
  assign comparator_trip = (charge >= TRIP_LEVEL);
endmodule : ctu_sensor_model

// >>> sim/tb.sv
// testbench: charge timer unit against a cycle model of flags and source
`timescale 1ns/100ps
module tb;
  import ctu_pkg::*;
  logic          clk = 0;
  logic          rst = 1;
  logic          sleep = 0, idle = 0, pd = 0, en = 0, sidl = 0, dly = 0;
  logic          gate = 0, ord = 0, dis = 0;
  logic [1:0]    rng = 2'h0;
  ctu_edge_cfg_t c1 = '0, c2 = '0;
  logic          wr1 = 0, wd1 = 0, wr2 = 0, wd2 = 0;
  logic [3:0]    lv = 4'h0;
  logic          trip, f1, f2, on, gnd, pls;
  logic          go = 0, adone;
  int            ares;
  logic [1:0]    srng;
  bit            m1, m2, mp;
  int            err_count = 0, compares = 0, seed = 2342;

  always #4 clk = ~clk;

  ctu_charge_timer i_dut (.clk(clk), .rst(rst), .sleep_mode(sleep),
    .idle_mode(idle), .peripheral_disable(pd), .unit_enable(en),
    .stop_in_idle(sidl), .delay_gen_enable(dly), .edge_gate(gate),
    .edge_order_enable(ord), .discharge_ground(dis), .current_range(rng),
    .first_edge_cfg(c1), .second_edge_cfg(c2), .first_flag_wr(wr1),
    .first_flag_wdata(wd1), .second_flag_wr(wr2), .second_flag_wdata(wd2),
    .first_edge_pin(lv[3]), .second_edge_pin(lv[2]),
    .enhanced_capture_one(lv[1]), .capture_unit_two(lv[0]),
    .comparator_trip(trip), .first_edge_flag(f1), .second_edge_flag(f2),
    .source_on(on), .source_range(srng), .source_grounded(gnd),
    .pulse_out_pin(pls));

  ctu_sensor_model i_sensor (.clk(clk), .source_on(on),
    .source_grounded(gnd), .adc_go(go), .comparator_trip(trip),
    .adc_done_flag(adone), .adc_result(ares));

  task automatic print_verdict;
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  // one edge for registered outputs to follow, then compare mid-cycle
  task automatic chk;
    logic       x;
    logic [6:0] e;
    @(posedge clk);
    @(negedge clk);
    x = en & (rng != 2'h0) & ~dis & m1 & ~m2 & ~sleep & ~(idle & sidl) & ~pd;
    e = {m1, m2, x, x ? rng : 2'h0, en & dis, mp};
    compares++;
    if ({f1, f2, on, srng, gnd, pls} !== e) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time,
               {f1, f2, on, srng, gnd, pls}, e);
    end
  endtask : chk

  // compare a converter result
  task automatic chk_val(input int got, input int exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_val

  // converter run: start, wait for done, take the result at done
  task automatic adc_read(output int r);
    int n;
    @(posedge clk);
    go <= 1;
    @(posedge clk);
    go <= 0;
    @(posedge clk);
    for (n = 0; n < 50 && adone !== 1'b1; n++)
      @(posedge clk);
    if (adone !== 1'b1) err_count++;
    r = ares;
  endtask : adc_read

  // software flag write; frozen while the peripheral is disabled
  task automatic swr(input int w, input bit v);
    @(posedge clk);
    if (w == 1) begin
      wr1 <= 1;
      wd1 <= v;
    end else begin
      wr2 <= 1;
      wd2 <= v;
    end
    @(posedge clk);
    wr1 <= 0;
    wr2 <= 0;
    if (!pd && w == 1) m1 = v;
    if (!pd && w == 2) m2 = v;
    if (w == 1 && !v) mp = 0;
    chk();
  endtask : swr

  // edge event of polarity p on source code k
  task automatic evt(input int k, input bit p);
    bit o;
    @(posedge clk);
    lv[k] <= !p;
    repeat (4) @(posedge clk);
    lv[k] <= p;
    repeat (4) @(posedge clk);
    o = m1;
    if (en && gate && c1.source == k && c1.polarity == p) m1 = 1;
    if (en && gate && c2.source == k && c2.polarity == p && (!ord || o))
      m2 = 1;
    chk();
  endtask : evt

  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    print_verdict();
  end

  initial begin
    int s;
    bit p;
    int r1, r2;
    repeat (8) @(posedge clk);
    rst <= 0;
    chk();
    @(posedge clk);
    en <= 1;
    rng <= 2'({$random(seed)} % 3 + 1);
    c1 <= '{source: CTU_SRC_PIN1, polarity: 1'b1};
    c2 <= '{source: CTU_SRC_PIN2, polarity: 1'b1};
    swr(1, 0);
    swr(2, 0);
    @(posedge clk);
    dis <= 1;
    chk();
    @(posedge clk);
    dis <= 0;
    swr(1, 1);
    for (s = 0; s < 4; s++) begin
      @(posedge clk);
      rng <= 2'(s);
      chk();
    end
    @(posedge clk);
    sleep <= 1;
    chk();
    @(posedge clk);
    sleep <= 0;
    idle <= 1;
    chk();
    @(posedge clk);
    sidl <= 1;
    chk();
    @(posedge clk);
    idle <= 0;
    dis <= 1;
    chk();
    @(posedge clk);
    dis <= 0;
    swr(1, 0);
    adc_read(r1);
    adc_read(r2);
    chk_val(r2, r1);
    @(posedge clk);
    pd <= 1;
    swr(1, 1);
    @(posedge clk);
    pd <= 0;
    evt(3, 1);
    @(posedge clk);
    gate <= 1;
    ord <= 1;
    evt(2, 1);
    evt(3, 1);
    evt(2, 1);
    swr(1, 0);
    swr(2, 0);
    @(posedge clk);
    ord <= 0;
    // random polarity per source; the other edge watches another source
    for (s = 0; s < 4; s++) begin
      p = 1'($random(seed)) ^ s[0];
      @(posedge clk);
      c1 <= '{source: 2'(s), polarity: p};
      c2 <= '{source: 2'(s + 1), polarity: p};
      evt(s, p);
      swr(1, 0);
    end
    @(posedge clk);
    dis <= 1;
    chk();
    adc_read(r1);
    chk_val(r1, 0);
    @(posedge clk);
    dis <= 0;
    dly <= 1;
    swr(1, 1);
    for (s = 0; s < 60 && pls !== 1'b1; s++)
      @(negedge clk);
    mp = 1;
    chk();
    swr(1, 0);
    swr(1, 1);
    @(posedge clk);
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    m1 = 0;
    chk();
    print_verdict();
  end
endmodule : tb
